// ===== rtl/rtos_pkg.sv
// constants, register indices and state type of the return-to-origin sequencer
package rtos_pkg;

  // ****************************************************************
  // clocking and limits
  // ****************************************************************
  localparam logic [24:0] CLK_HZ      = 25'h17D7840;
  localparam logic [19:0] SPD_MAX     = 20'hF4240;
  localparam logic [19:0] FINAL_MAX   = 20'h001F4;
  localparam logic [23:0] FIXED_STEPS = 24'h0000C8;
  localparam logic [9:0]  CUR_MAX     = 10'h3E8;

  // ****************************************************************
  // homing modes
  // ****************************************************************
  localparam logic [1:0] MODE_2S   = 2'h0;
  localparam logic [1:0] MODE_3S   = 2'h1;
  localparam logic [1:0] MODE_PUSH = 2'h2;

  // ****************************************************************
  // register word indices on the bus
  // ****************************************************************
  localparam logic [3:0] IDX_MODE   = 4'h0;
  localparam logic [3:0] IDX_SEEK   = 4'h1;
  localparam logic [3:0] IDX_ACCEL  = 4'h2;
  localparam logic [3:0] IDX_START  = 4'h3;
  localparam logic [3:0] IDX_OFFSET = 4'h4;
  localparam logic [3:0] IDX_DIR    = 4'h5;
  localparam logic [3:0] IDX_AUXEN  = 4'h6;
  localparam logic [3:0] IDX_PHZEN  = 4'h7;
  localparam logic [3:0] IDX_CUR    = 4'h8;
  localparam logic [3:0] IDX_PRESET = 4'h9;
  localparam logic [3:0] IDX_CTRL   = 4'hA;
  localparam logic [3:0] IDX_STATUS = 4'hB;
  localparam logic [3:0] IDX_POS    = 4'hC;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int          CTRL_PRESET_BIT = 0;
  localparam logic [1:0]  RST_MODE   = MODE_3S;
  localparam logic [19:0] RST_SEEK   = 20'h003E8;
  localparam logic [19:0] RST_ACCEL  = 20'h003E8;
  localparam logic [19:0] RST_START  = 20'h001F4;
  localparam logic [23:0] RST_OFFSET = 24'h000000;
  localparam logic        RST_DIR    = 1'h1;
  localparam logic        RST_AUXEN  = 1'h0;
  localparam logic        RST_PHZEN  = 1'h0;
  localparam logic [9:0]  RST_CUR    = 10'h3E8;
  localparam logic [31:0] RST_PRESET = 32'h00000000;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_SEEK   = 6'h02,
    ST_ESCAPE = 6'h04,
    ST_FIXED  = 6'h08,
    ST_QUAL   = 6'h10,
    ST_OFFSET = 6'h20
  } rtos_state_t;

endpackage

// ===== rtl/rtos_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module rtos_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ===== rtl/rtos_stepgen.sv
// phase-accumulator step pulse generator, rate given in Hz
`timescale 1ns/1ps
module rtos_stepgen
  import rtos_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic [19:0] speed,
  output logic             step
);

  logic [24:0] acc_reg;
  wire  [24:0] sum  = acc_reg + {5'h00, speed};
  wire         wrap = sum >= CLK_HZ;

  // accumulator clears while stopped so each move starts a full period late
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_reg <= 25'h0000000;
      step    <= 1'h0;
    end
    else if (!run)
    begin
      acc_reg <= 25'h0000000;
      step    <= 1'h0;
    end
    else
    begin
      acc_reg <= wrap ? sum - CLK_HZ : sum;
      step    <= wrap;
    end
  end

endmodule

// ===== rtl/rtos_top.sv
// return-to-origin sequencer with avalon-mm configuration registers
`timescale 1ns/1ps

// Summary of operation
// - mode register picks two-sensor, three-sensor or push homing; resets to three-sensor
// - seek speed accepts 1 to 1000000 Hz, default 1000, used for fast travel
// - acceleration setting accepts 1 to 1000000, default 1000
// - start speed accepts 1 to 1000000 Hz, default 500, used for slow travel
// - signed origin offset of 24 bits, default zero
// - after mechanical origin, move by the offset; that stop is the electrical origin
// - search starts negative for 0, positive for 1; default positive
// - aux origin input qualifies the origin only when its enable is 1
// - phase-zero signal qualifies the origin only when its enable is 1
// - push current setting 0 to 1000 in 0.1 % steps, default 1000
// - preset command while stopped loads command position from preset register
// - ready drops when homing begins; host releases request after seeing it off
// - origin-reached output turns on when homing completes
// - final approach speed is start speed below 500 Hz, else 500 Hz
// - with aux enabled in three-sensor mode, finish on aux while origin sensor on
// - three-sensor mode seeks at seek speed and stops at the origin sensor
// - two-sensor mode travels 200 steps after leaving the limit, then stops
module rtos_top
  import rtos_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        HOME_REQ,
  input  wire logic        ORIGIN_SENSOR,
  input  wire logic        POSITIVE_LIMIT_SENSOR,
  input  wire logic        NEGATIVE_LIMIT_SENSOR,
  input  wire logic        AUX_ORIGIN_INPUT,
  input  wire logic        PHASE_ZERO_SIGNAL,
  input  wire logic        PUSH_CONTACT,
  output logic             READY,
  output logic             ORIGIN_REACHED,
  output logic             STEP,
  output logic             DIR
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [6:0] pins_s;

  rtos_sync #(.W(7)) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     ({PUSH_CONTACT, PHASE_ZERO_SIGNAL, AUX_ORIGIN_INPUT, NEGATIVE_LIMIT_SENSOR,
             POSITIVE_LIMIT_SENSOR, ORIGIN_SENSOR, HOME_REQ}),
    .q     (pins_s)
  );

  wire home_req_s = pins_s[0];
  wire origin_s   = pins_s[1];
  wire pos_lim_s  = pins_s[2];
  wire neg_lim_s  = pins_s[3];
  wire aux_s      = pins_s[4];
  wire phz_s      = pins_s[5];
  wire contact_s  = pins_s[6];

  // ****************************************************************
  // configuration and state registers
  // ****************************************************************
  logic [1:0]  mode_reg;
  logic [19:0] seek_reg;
  logic [19:0] accel_reg;
  logic [19:0] start_reg;
  logic [23:0] offset_reg;
  logic        dir_cfg_reg;
  logic        aux_en_reg;
  logic        phz_en_reg;
  logic [9:0]  cur_reg;
  logic [31:0] preset_reg;
  rtos_state_t st_reg;
  rtos_state_t st_next;
  logic        dir_reg;
  logic        dir_next;
  logic [31:0] pos_reg;
  logic [31:0] pos_next;
  logic [23:0] cnt_reg;
  logic [23:0] cnt_next;
  logic        done_reg;
  logic        done_next;
  logic        origin_prev_reg;
  logic        ack_reg;
  logic        found;
  logic        step;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // one wait state per access; partial-word writes are ignored
  wire        req     = AVS_READ | AVS_WRITE;
  wire        wr_en   = AVS_WRITE & ack_reg & (AVS_BYTEENABLE == 4'hF);
  wire [31:0] wv      = AVS_WRITEDATA;
  wire        spd_ok  = (wv != 32'h00000000) && (wv <= {12'h000, SPD_MAX});
  wire        we_mode = wr_en && (AVS_ADDRESS == IDX_MODE) && (wv <= {30'h00000000, MODE_PUSH});
  wire        we_seek = wr_en && (AVS_ADDRESS == IDX_SEEK) && spd_ok;
  wire        we_acc  = wr_en && (AVS_ADDRESS == IDX_ACCEL) && spd_ok;
  wire        we_strt = wr_en && (AVS_ADDRESS == IDX_START) && spd_ok;
  wire        off_ok  = (wv[31:23] == 9'h000) || (wv[31:23] == 9'h1FF);
  wire        we_off  = wr_en && (AVS_ADDRESS == IDX_OFFSET) && off_ok;
  wire        we_dir  = wr_en && (AVS_ADDRESS == IDX_DIR);
  wire        we_aux  = wr_en && (AVS_ADDRESS == IDX_AUXEN);
  wire        we_phz  = wr_en && (AVS_ADDRESS == IDX_PHZEN);
  wire        we_cur  = wr_en && (AVS_ADDRESS == IDX_CUR) && (wv <= {22'h000000, CUR_MAX});
  wire        we_pre  = wr_en && (AVS_ADDRESS == IDX_PRESET);
  wire        preset_cmd = wr_en && (AVS_ADDRESS == IDX_CTRL) && wv[CTRL_PRESET_BIT];

  assign AVS_WAITREQUEST = req & ~ack_reg;

  wire [31:0] rd_mux =
    (AVS_ADDRESS == IDX_MODE)   ? {30'h00000000, mode_reg} :
    (AVS_ADDRESS == IDX_SEEK)   ? {12'h000, seek_reg} :
    (AVS_ADDRESS == IDX_ACCEL)  ? {12'h000, accel_reg} :
    (AVS_ADDRESS == IDX_START)  ? {12'h000, start_reg} :
    (AVS_ADDRESS == IDX_OFFSET) ? {{8{offset_reg[23]}}, offset_reg} :
    (AVS_ADDRESS == IDX_DIR)    ? {31'h00000000, dir_cfg_reg} :
    (AVS_ADDRESS == IDX_AUXEN)  ? {31'h00000000, aux_en_reg} :
    (AVS_ADDRESS == IDX_PHZEN)  ? {31'h00000000, phz_en_reg} :
    (AVS_ADDRESS == IDX_CUR)    ? {22'h000000, cur_reg} :
    (AVS_ADDRESS == IDX_PRESET) ? preset_reg :
    (AVS_ADDRESS == IDX_STATUS) ? {24'h000000, st_reg, done_reg, READY} :
    (AVS_ADDRESS == IDX_POS)    ? pos_reg : 32'h00000000;

  // ****************************************************************
  // sequencer decode
  // ****************************************************************
  wire        idle        = (st_reg == ST_IDLE);
  wire        start       = idle & home_req_s;
  wire        origin_rise = origin_s & ~origin_prev_reg;
  wire        push_mode   = (mode_reg == MODE_PUSH);
  wire        lim_fwd     = push_mode ? contact_s : (dir_reg ? pos_lim_s : neg_lim_s);
  wire        lim_back    = push_mode ? contact_s : (dir_reg ? neg_lim_s : pos_lim_s);
  wire        aux_on      = aux_en_reg | phz_en_reg;
  wire        aux_hit     = (aux_en_reg & aux_s) | (phz_en_reg & phz_s);
  wire        qual_ok     = aux_hit & ((mode_reg != MODE_3S) | origin_s);
  wire [19:0] final_spd   = (start_reg < FINAL_MAX) ? start_reg : FINAL_MAX;
  wire [23:0] off_mag     = offset_reg[23] ? 24'h000000 - offset_reg : offset_reg;
  // acceleration is held for software only; the step generator runs flat
  wire [19:0] speed =
    (st_reg == ST_SEEK)   ? ((mode_reg == MODE_3S) ? seek_reg : start_reg) :
    (st_reg == ST_ESCAPE) ? start_reg :
    (st_reg == ST_FIXED)  ? final_spd :
    (st_reg == ST_QUAL)   ? final_spd :
    (st_reg == ST_OFFSET) ? seek_reg : 20'h00000;

  assign READY          = idle;
  assign ORIGIN_REACHED = done_reg;
  assign DIR            = dir_reg;

  rtos_stepgen u_step (
    .clk   (CLK),
    .rst_n (RST_N),
    .run   (~idle),
    .speed (speed),
    .step  (step)
  );

  assign STEP = step;

  // ****************************************************************
  // homing sequence
  // ****************************************************************
  always_comb
  begin
    st_next   = st_reg;
    dir_next  = dir_reg;
    cnt_next  = cnt_reg;
    pos_next  = pos_reg;
    done_next = done_reg;
    found     = 1'h0;
    if (step)
      pos_next = dir_reg ? pos_reg + 32'h00000001 : pos_reg - 32'h00000001;
    case (st_reg)
      ST_IDLE:
      begin
        if (start)
        begin
          st_next   = ST_SEEK;
          dir_next  = dir_cfg_reg;
          done_next = 1'h0;
        end
        else if (preset_cmd)
          pos_next = preset_reg;
      end
      ST_SEEK:
      begin
        if (mode_reg == MODE_3S)
        begin
          if (origin_rise)
          begin
            if (aux_on)
              st_next = ST_QUAL;
            else
              found = 1'h1;
          end
          else if (lim_fwd)
            dir_next = ~dir_reg;
        end
        else if (lim_fwd)
        begin
          dir_next = ~dir_reg;
          st_next  = ST_ESCAPE;
        end
      end
      ST_ESCAPE:
      begin
        if (!lim_back)
        begin
          st_next  = ST_FIXED;
          cnt_next = FIXED_STEPS;
        end
      end
      ST_FIXED:
      begin
        if (step)
        begin
          cnt_next = cnt_reg - 24'h000001;
          if (cnt_reg == 24'h000001)
          begin
            if (aux_on)
              st_next = ST_QUAL;
            else
              found = 1'h1;
          end
        end
      end
      ST_QUAL:
      begin
        if (qual_ok)
          found = 1'h1;
        else if (lim_fwd)
          dir_next = ~dir_reg;
      end
      ST_OFFSET:
      begin
        if (step)
        begin
          cnt_next = cnt_reg - 24'h000001;
          if (cnt_reg == 24'h000001)
          begin
            st_next   = ST_IDLE;
            done_next = 1'h1;
            pos_next  = 32'h00000000;
          end
        end
      end
      default:
        st_next = ST_IDLE;
    endcase
    if (found)
    begin
      pos_next = 32'h00000000;
      if (off_mag == 24'h000000)
      begin
        st_next   = ST_IDLE;
        done_next = 1'h1;
      end
      else
      begin
        st_next  = ST_OFFSET;
        cnt_next = off_mag;
        dir_next = ~offset_reg[23];
      end
    end
  end

  // a request seen while busy never reaches the start decode
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_reg          <= ST_IDLE;
      dir_reg         <= 1'h0;
      pos_reg         <= 32'h00000000;
      cnt_reg         <= 24'h000000;
      done_reg        <= 1'h0;
      origin_prev_reg <= 1'h0;
    end
    else
    begin
      st_reg          <= st_next;
      dir_reg         <= dir_next;
      pos_reg         <= pos_next;
      cnt_reg         <= cnt_next;
      done_reg        <= done_next;
      origin_prev_reg <= origin_s;
    end
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ack_reg      <= 1'h0;
      AVS_READDATA <= 32'h00000000;
    end
    else
    begin
      ack_reg      <= req & ~ack_reg;
      AVS_READDATA <= rd_mux;
    end
  end

  // out-of-range values are dropped so settings always stay legal
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mode_reg    <= RST_MODE;
      seek_reg    <= RST_SEEK;
      accel_reg   <= RST_ACCEL;
      start_reg   <= RST_START;
      offset_reg  <= RST_OFFSET;
      dir_cfg_reg <= RST_DIR;
      aux_en_reg  <= RST_AUXEN;
      phz_en_reg  <= RST_PHZEN;
      cur_reg     <= RST_CUR;
      preset_reg  <= RST_PRESET;
    end
    else
    begin
      if (we_mode) mode_reg <= wv[1:0];
      if (we_seek) seek_reg <= wv[19:0];
      if (we_acc) accel_reg <= wv[19:0];
      if (we_strt) start_reg <= wv[19:0];
      if (we_off) offset_reg <= wv[23:0];
      if (we_dir) dir_cfg_reg <= wv[0];
      if (we_aux) aux_en_reg <= wv[0];
      if (we_phz) phz_en_reg <= wv[0];
      if (we_cur) cur_reg <= wv[9:0];
      if (we_pre) preset_reg <= wv;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_start;
    idle && home_req_s;
  endsequence

  sequence s_last_offset;
    (st_reg == ST_OFFSET) && step && (cnt_reg == 24'h000001);
  endsequence

  mode_range_a: assert property (mode_reg <= MODE_PUSH)
    else $error("homing mode out of range");
  seek_range_a: assert property (seek_reg != 20'h00000 && seek_reg <= SPD_MAX)
    else $error("seek speed out of range");
  accel_range_a: assert property (accel_reg != 20'h00000 && accel_reg <= SPD_MAX)
    else $error("acceleration out of range");
  start_range_a: assert property (start_reg != 20'h00000 && start_reg <= SPD_MAX)
    else $error("start speed out of range");
  cur_range_a: assert property (cur_reg <= CUR_MAX)
    else $error("push current out of range");
  start_dir_a: assert property (s_start |=> dir_reg == $past(dir_cfg_reg))
    else $error("search did not start in configured direction");
  ready_drop_a: assert property (s_start |=> !READY && !ORIGIN_REACHED)
    else $error("ready still on after homing began");
  offset_done_a: assert property (s_last_offset |=> ORIGIN_REACHED && READY && pos_reg == 32'h00000000)
    else $error("offset move end did not complete homing");
  found_zero_a: assert property (found |=> pos_reg == 32'h00000000)
    else $error("command position not zeroed at origin");
  final_speed_a: assert property ((st_reg == ST_FIXED || st_reg == ST_QUAL) |->
    speed <= FINAL_MAX && speed <= start_reg && (speed == FINAL_MAX || speed == start_reg))
    else $error("final approach speed wrong");
  qual_hold_a: assert property (st_reg == ST_QUAL && mode_reg == MODE_3S && !origin_s |=> !ORIGIN_REACHED)
    else $error("completed without origin sensor on");
  fixed_count_a: assert property ($rose(st_reg == ST_FIXED) |-> cnt_reg == FIXED_STEPS)
    else $error("fixed travel count wrong");
  preset_load_a: assert property (preset_cmd && idle && !home_req_s |=> pos_reg == $past(preset_reg))
    else $error("preset did not load command position");
  // a search only ever opens from idle, never from a running sequence
  busy_ignore_a: assert property (!idle && home_req_s |=> st_reg != ST_SEEK || $past(st_reg) == ST_SEEK)
    else $error("request disturbed a running sequence");

endmodule

// ===== verification/rtos_axis_model.sv
// axis model behind the sequencer: position count and sensors
`timescale 1ns/1ps
module rtos_axis_model #(
  parameter int ORG_LO = 10,
  parameter int ORG_HI = 20
) (
  input  wire logic               clk,
  input  wire logic               step,
  input  wire logic               dir,
  input  wire logic               place,
  input  wire logic signed [31:0] place_pos,
  output logic signed [31:0]      pos,
  output logic                    origin,
  output logic                    lim_pos,
  output logic                    lim_neg,
  output logic                    aux,
  output logic                    phz
);
  initial pos = 32'h0;
  always @(posedge clk)
  begin
    if (place)
      pos <= place_pos;
    else if (step)
      pos <= dir ? pos + 32'sh1 : pos - 32'sh1;
  end
  assign origin  = (pos >= ORG_LO) && (pos <= ORG_HI);
  assign lim_pos = pos >= 60;
  assign lim_neg = pos <= -60;
  // qualifiers sit one step inside the origin band, so a stop at its edge shows
  assign aux     = pos == ORG_LO + 1;
  // phase zero repeats every 50 steps with the resolution kept a multiple of 50
  assign phz     = (pos % 50) == ORG_LO + 1;
endmodule

// ===== verification/rtos_top_tb.sv
// self-checking bench for the return-to-origin sequencer
`timescale 1ns/1ps
module rtos_top_tb
  import rtos_pkg::*;
;
  logic               CLK = 1'h0;
  logic               RST_N = 1'h0;
  logic [3:0]         AVS_ADDRESS = 4'h0;
  logic               AVS_READ = 1'h0;
  logic               AVS_WRITE = 1'h0;
  logic [31:0]        AVS_WRITEDATA = 32'h0;
  logic [3:0]         AVS_BYTEENABLE = 4'hF;
  logic [31:0]        AVS_READDATA;
  logic               AVS_WAITREQUEST;
  logic               HOME_REQ = 1'h0;
  logic               origin;
  logic               lim_pos;
  logic               lim_neg;
  logic               aux;
  logic               phz;
  logic               READY;
  logic               ORIGIN_REACHED;
  logic               STEP;
  logic               DIR;
  logic               mplace = 1'h0;
  logic signed [31:0] mpos = 32'h0;
  logic signed [31:0] model_pos;
  int                 fail_count = 0;
  int                 checked = 0;

  rtos_top rtos_top_i (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .HOME_REQ(HOME_REQ),
    .ORIGIN_SENSOR(origin), .POSITIVE_LIMIT_SENSOR(lim_pos), .NEGATIVE_LIMIT_SENSOR(lim_neg),
    .AUX_ORIGIN_INPUT(aux), .PHASE_ZERO_SIGNAL(phz), .PUSH_CONTACT(lim_pos | lim_neg), .READY(READY),
    .ORIGIN_REACHED(ORIGIN_REACHED), .STEP(STEP), .DIR(DIR));

  rtos_axis_model rtos_axis_model_i (.clk(CLK), .step(STEP), .dir(DIR), .place(mplace),
    .place_pos(mpos), .pos(model_pos), .origin(origin), .lim_pos(lim_pos), .lim_neg(lim_neg),
    .aux(aux), .phz(phz));

  initial
  begin
    forever #20 CLK = ~CLK;
  end

  // ****************************************************************
  // checking and closing
  // ****************************************************************
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    fail_count++;
    $display("BAD t=%0t seen=%h exp=%h (wait ran out)", $time, 32'h0, 32'h1);
    give_verdict();
  endtask

  // ****************************************************************
  // bus access
  // ****************************************************************
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (AVS_WAITREQUEST !== 1'h0 && n < 50);
    q = AVS_READDATA;
    AVS_WRITE <= 1'h0;
    AVS_READ <= 1'h0;
    if (n >= 50)
      hang();
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    check(q, exp);
  endtask

  task automatic wc(input logic [3:0] a, input logic [31:0] d, input logic [31:0] exp);
    wr(a, d);
    rd_chk(a, exp);
  endtask

  // place the axis, raise the request, release it once ready is off
  task automatic go(input int start, input logic dir_exp);
    int n;
    @(posedge CLK);
    mplace <= 1'h1;
    mpos <= 32'(start);
    @(posedge CLK);
    mplace <= 1'h0;
    HOME_REQ <= 1'h1;
    n = 0;
    do
    begin
      @(negedge CLK);
      n++;
    end
    while (READY !== 1'h0 && n < 20);
    if (n >= 20)
      hang();
    check(32'(ORIGIN_REACHED), 32'h0);
    check(32'(DIR), 32'(dir_exp));
    @(posedge CLK);
    HOME_REQ <= 1'h0;
  endtask

  // home from a start point and judge the stop point
  task automatic home(input int start, input int stop_exp, input logic dir_exp);
    int n;
    go(start, dir_exp);
    n = 0;
    do
    begin
      @(negedge CLK);
      n++;
    end
    while (ORIGIN_REACHED !== 1'h1 && n < 60000);
    if (n >= 60000)
      hang();
    check(32'(READY), 32'h1);
    check(model_pos, 32'(stop_exp));
    rd_chk(IDX_POS, 32'h0);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd_chk(IDX_MODE, 32'h1);
    rd_chk(IDX_SEEK, 32'h3E8);
    rd_chk(IDX_ACCEL, 32'h3E8);
    rd_chk(IDX_START, 32'h1F4);
    rd_chk(IDX_OFFSET, 32'h0);
    rd_chk(IDX_DIR, 32'h1);
    rd_chk(IDX_AUXEN, 32'h0);
    rd_chk(IDX_PHZEN, 32'h0);
    rd_chk(IDX_CUR, 32'h3E8);
    rd_chk(IDX_STATUS, 32'h5);
    rd_chk(4'hD, 32'h0);
  endtask

  task automatic t_limits();
    wc(IDX_MODE, 32'h3, 32'h1);
    wc(IDX_MODE, 32'h2, 32'h2);
    wc(IDX_MODE, 32'h0, 32'h0);
    wc(IDX_MODE, 32'h1, 32'h1);
    wc(IDX_SEEK, 32'h0, 32'h3E8);
    wc(IDX_SEEK, 32'hF4241, 32'h3E8);
    wc(IDX_SEEK, 32'hF4240, 32'hF4240);
    wc(IDX_ACCEL, 32'h0, 32'h3E8);
    wc(IDX_ACCEL, 32'hF4240, 32'hF4240);
    wc(IDX_START, 32'hF4241, 32'h1F4);
    wc(IDX_START, 32'h1, 32'h1);
    wc(IDX_START, 32'h1F4, 32'h1F4);
    wc(IDX_OFFSET, 32'h800000, 32'h0);
    wc(IDX_OFFSET, 32'hFF800000, 32'hFF800000);
    wc(IDX_OFFSET, 32'h0, 32'h0);
    wc(IDX_CUR, 32'h3E9, 32'h3E8);
    wc(IDX_CUR, 32'h0, 32'h0);
    AVS_BYTEENABLE <= 4'h3;
    wc(IDX_CUR, 32'h5, 32'h0);
    AVS_BYTEENABLE <= 4'hF;
  endtask

  task automatic t_homing();
    home(-20, 10, 1'h1);
    rd_chk(IDX_STATUS, 32'h7);
    wr(IDX_OFFSET, 32'hFFFFFFFB);
    wr(IDX_DIR, 32'h0);
    home(40, 15, 1'h0);
    wr(IDX_OFFSET, 32'h0);
    wr(IDX_DIR, 32'h1);
    wr(IDX_AUXEN, 32'h1);
    home(-20, 11, 1'h1);
    wr(IDX_AUXEN, 32'h0);
    wr(IDX_PHZEN, 32'h1);
    home(-20, 11, 1'h1);
    wr(IDX_PHZEN, 32'h0);
  endtask

  task automatic t_preset();
    wr(IDX_PRESET, 32'h80000123);
    wr(IDX_CTRL, 32'h1);
    rd_chk(IDX_POS, 32'h80000123);
    rd_chk(IDX_CTRL, 32'h0);
  endtask

  // two-sensor and push modes: leave the end at start speed; the slow 200-step leg is cut by a reset
  task automatic t_escape(input logic [1:0] m);
    logic [31:0] q;
    int          n;
    wr(IDX_MODE, 32'(m));
    wr(IDX_START, 32'hF4240);
    go(70, 1'h1);
    n = 0;
    do
    begin
      bus(1'h0, IDX_STATUS, 32'h0, q);
      n++;
    end
    while (q !== 32'h20 && n < 300);
    if (n >= 300)
      hang();
    check(model_pos, 32'h3B);
    check(32'(DIR), 32'h0);
    HOME_REQ <= 1'h1;
    rd_chk(IDX_STATUS, 32'h20);
    rd_chk(IDX_STATUS, 32'h20);
    HOME_REQ <= 1'h0;
    RST_N <= 1'h0;
    @(posedge CLK);
    RST_N <= 1'h1;
    @(negedge CLK);
    check(32'(READY), 32'h1);
    rd_chk(IDX_MODE, 32'h1);
    rd_chk(IDX_STATUS, 32'h5);
  endtask

  initial
  begin
    repeat (12) @(posedge CLK);
    RST_N <= 1'h1;
    t_reset();
    t_limits();
    t_homing();
    t_preset();
    t_escape(MODE_2S);
    t_escape(MODE_PUSH);
    give_verdict();
  end
endmodule
